// ===== bench/core_model.sv
// Processor core model that takes an offered interrupt after a set delay.
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic clock_in, // System clock
  input wire logic srst_in, // Synchronous reset, active high
  input wire pie_pkg::delivery_t delivery_in, // Offered request
  input wire logic ack_enable_in, // Core accepts interrupts
  input wire logic [3:0] ack_delay_in, // Offer cycles before taking
  output logic core_ack_out // One-cycle take pulse
);
  logic [3:0] wait_q;
  // The take is only raised if an offer stood at the edge before, so it lands idle if the offer drops on that edge.
  always_ff @(posedge clock_in) begin
    if (srst_in || core_ack_out || !delivery_in.req || !ack_enable_in) begin
      wait_q <= 4'h0;
      core_ack_out <= 1'b0;
    end else if (wait_q == ack_delay_in) begin
      core_ack_out <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : core_model
`default_nettype wire

// ===== bench/prioritized_interrupt_enable_tb.sv
// Self-checking testbench of the prioritized interrupt controller.
`timescale 1ns/10ps
`default_nettype none
module prioritized_interrupt_enable_tb;
  logic clock_in;
  logic srst_in;
  pie_pkg::bus_req_t bus_in;
  logic [7:0] rd_data_out;
  logic [7:0] g0_src;
  logic [7:0] g1_src;
  logic [3:0] pins;
  logic [2:0] instr_q;
  logic core_ack;
  pie_pkg::delivery_t delivery_out;
  logic int_out;
  logic ack_enable;
  logic [3:0] ack_delay;
  int errors;
  int checks;
  int cycles;
  logic [11:0] clear_list [10];
  // ==========================================================================
  // Instances
  prioritized_interrupt_enable DUT (.clock_in(clock_in), .srst_in(srst_in),
    .bus_in(bus_in), .rd_data_out(rd_data_out), .group0_src_in(g0_src),
    .group1_src_in(g1_src), .portc_pins_in(pins),
    .enable_int_instr_in(instr_q[2]), .return_from_int_instr_in(instr_q[1]),
    .disable_int_instr_in(instr_q[0]), .core_ack_in(core_ack),
    .delivery_out(delivery_out), .int_out(int_out));
  core_model core (.clock_in(clock_in), .srst_in(srst_in),
    .delivery_in(delivery_out), .ack_enable_in(ack_enable),
    .ack_delay_in(ack_delay), .core_ack_out(core_ack));
  // ==========================================================================
  // Comparison and bus tasks
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  task automatic fail(input string msg);
    errors++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask : fail
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("byte %h, expected %h", got, exp));
  endtask : check8
  task automatic check1(input logic got, input logic exp);
    checks++;
    if (got !== exp) fail($sformatf("flag %b, expected %b", got, exp));
  endtask : check1
  task automatic check_dlv(input logic [1:0] lvl, input logic [15:0] vec);
    checks++;
    if (delivery_out !== {1'b1, lvl, vec}) fail("wrong offer to core");
  endtask : check_dlv
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    bus_in.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_in);
    bus_in.rd <= 1'b0;
    #1;
    check8(rd_data_out, exp);
  endtask : rd
  task automatic pulse(input logic [7:0] g0, input logic [7:0] g1);
    @(posedge clock_in);
    g0_src <= g0;
    g1_src <= g1;
    @(posedge clock_in);
    g0_src <= 8'h00;
    g1_src <= 8'h00;
  endtask : pulse
  task automatic instr(input logic [2:0] k);
    @(posedge clock_in);
    instr_q <= k;
    @(posedge clock_in);
    instr_q <= 3'h0;
  endtask : instr
  task automatic wait_req(input logic want);
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      #1;
      n++;
    end while (delivery_out.req !== want && n < 10);
    check1(delivery_out.req, want);
  endtask : wait_req
  task automatic quiet();
    repeat (4) @(posedge clock_in);
    #1;
    check1(delivery_out.req, 1'b0);
  endtask : quiet
  task automatic cleanup();
    foreach (clear_list[i]) wr(clear_list[i], 8'h00);
  endtask : cleanup
  // ==========================================================================
  // Scenarios
  task automatic test_registers();
    rd(12'hFC1, 8'h00);
    rd(12'hFC2, 8'h00);
    rd(12'hFC6, 8'h00);
    wr(12'hFC2, 8'hFF);
    rd(12'hFC2, 8'h79);
    wr(12'hFC1, 8'hFF);
    rd(12'hFC1, 8'hFF);
    wr(12'hFC6, 8'hFF);
    rd(12'hFC6, 8'h0F);
    wr(12'h000, 8'h5A);
    rd(12'h000, 8'h00);
    cleanup();
    $display("test registers done");
  endtask : test_registers
  task automatic test_master();
    wr(12'hFC1, 8'h40);
    wr(12'hFC2, 8'h40);
    pulse(8'h40, 8'h00);
    quiet();
    instr(3'h4);
    wait_req(1'b1);
    check_dlv(2'h3, 16'h0012);
    ack_enable <= 1'b1;
    ack_delay <= 4'h3;
    wait_req(1'b0);
    ack_enable <= 1'b0;
    rd(12'hFCF, 8'h00);
    rd(12'hFC0, 8'h00);
    rd(12'hFD0, 8'h01);
    check1(int_out, 1'b0);
    wr(12'hFD1, 8'h01);
    #1;
    check1(int_out, 1'b1);
    wr(12'hFD0, 8'h01);
    #1;
    check1(int_out, 1'b0);
    cleanup();
    $display("test master done");
  endtask : test_master
  task automatic test_instr();
    instr(3'h2);
    rd(12'hFCF, 8'h80);
    instr(3'h1);
    rd(12'hFCF, 8'h00);
    $display("test instructions done");
  endtask : test_instr
  task automatic test_priority();
    wr(12'hFC1, 8'h01);
    wr(12'hFC2, 8'h21);
    pulse(8'h21, 8'h00);
    wr(12'hFCF, 8'h80);
    wait_req(1'b1);
    check_dlv(2'h3, 16'h001E);
    wr(12'hFC1, 8'hA1);
    wr(12'hFC2, 8'h00);
    pulse(8'h80, 8'h00);
    repeat (2) @(posedge clock_in);
    #1;
    check_dlv(2'h2, 16'h0014);
    cleanup();
    $display("test priority done");
  endtask : test_priority
  task automatic test_group1();
    for (int c = 0; c < 4; c++) begin
      wr(12'hFC4, {7'h00, c[1]});
      wr(12'hFC5, {7'h00, c[0]});
      pulse(8'h00, 8'h01);
      wr(12'hFCF, 8'h80);
      if (c == 0) begin
        quiet();
      end else begin
        wait_req(1'b1);
        check_dlv(c[1:0], 16'h002E);
      end
      cleanup();
    end
    $display("test group1 done");
  endtask : test_group1
  task automatic test_portc();
    wr(12'hFC7, 8'h01);
    wr(12'hFC8, 8'h01);
    wr(12'hFCF, 8'h80);
    pins <= 4'h1;
    wait_req(1'b1);
    check_dlv(2'h3, 16'h0036);
    rd(12'hFC6, 8'h01);
    wr(12'hFCF, 8'h00);
    wr(12'hFC6, 8'h00);
    pins <= 4'h0;
    repeat (6) @(posedge clock_in);
    rd(12'hFC6, 8'h01);
    rd(12'hFD0, 8'h02);
    cleanup();
    $display("test port c done");
  endtask : test_portc
  // ==========================================================================
  // Clock, timeout and main sequence
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      fail("timeout");
      report_and_stop();
    end
  end
  initial begin
    errors = 0;
    checks = 0;
    cycles = 0;
    srst_in = 1'b1;
    bus_in = '0;
    g0_src = 8'h00;
    g1_src = 8'h00;
    pins = 4'h0;
    instr_q = 3'h0;
    ack_enable = 1'b0;
    ack_delay = 4'h0;
    clear_list = '{12'hFCF, 12'hFC0, 12'hFC3, 12'hFC6, 12'hFC1, 12'hFC2,
      12'hFC4, 12'hFC5, 12'hFC7, 12'hFC8};
    repeat (6) @(posedge clock_in);
    srst_in <= 1'b0;
    test_registers();
    test_master();
    test_instr();
    test_priority();
    test_group1();
    test_portc();
    report_and_stop();
  end
endmodule : prioritized_interrupt_enable_tb
`default_nettype wire

// ===== hw/find_highest.sv
// Finds the highest set bit of a request vector.
`timescale 1ns/10ps
`default_nettype none
module find_highest #(
  parameter int N = 20,
  parameter int W = 5
) (
  input wire logic [N-1:0] req_in, // Candidate requests
  output logic found_out, // Any bit set
  output logic [W-1:0] index_out // Highest set bit position
);
  always_comb begin
    found_out = 1'b0;
    index_out = '0;
    for (int i = 0; i < N; i++) begin
      if (req_in[i]) begin
        found_out = 1'b1;
        index_out = W'(i);
      end
    end
  end
endmodule : find_highest
`default_nettype wire

// ===== hw/pie_pkg.sv
// Constants, register map and carrier types of the interrupt controller.
// Operation
// - Master enable gates all delivery to core.
// - Enable-interrupt instruction sets master enable.
// - Return-from-interrupt instruction sets master enable.
// - Port C flags bits 3..0; 7..4 zero.
// - Group 0 high/low pair selects priority.
// - Group 1 uses same two-bit priority code.
// - Group 0 bit map; reserved low bits read zero.
// - Port C pin 0: both edges, lowest, 0036H.
`default_nettype none
package pie_pkg;
  // ==========================================================================
  // Register map
  localparam logic [11:0] GROUP0_FLAGS_OFS = 12'hFC0;
  localparam logic [11:0] GROUP0_EN_HIGH_OFS = 12'hFC1;
  localparam logic [11:0] GROUP0_EN_LOW_OFS = 12'hFC2;
  localparam logic [11:0] GROUP1_FLAGS_OFS = 12'hFC3;
  localparam logic [11:0] GROUP1_EN_HIGH_OFS = 12'hFC4;
  localparam logic [11:0] GROUP1_EN_LOW_OFS = 12'hFC5;
  localparam logic [11:0] PORTC_FLAGS_OFS = 12'hFC6;
  localparam logic [11:0] PORTC_EN_HIGH_OFS = 12'hFC7;
  localparam logic [11:0] PORTC_EN_LOW_OFS = 12'hFC8;
  localparam logic [11:0] INT_CONTROL_OFS = 12'hFCF;
  localparam logic [11:0] EVENT_STATUS_OFS = 12'hFD0;
  localparam logic [11:0] EVENT_MASK_OFS = 12'hFD1;
  // ==========================================================================
  // Field layouts and reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] GROUP0_MASK = 8'h79;
  localparam logic [7:0] GROUP1_MASK = 8'hFF;
  localparam logic [7:0] PORTC_MASK = 8'h0F;
  localparam int MASTER_ENABLE_BIT = 7;
  localparam int EVT_TAKEN_BIT = 0;
  localparam int EVT_PORTC_EDGE_BIT = 1;
  localparam logic [7:0] EVENT_MASK_BITS = 8'h03;
  // ==========================================================================
  // Sources and vectors
  localparam int SRC_COUNT = 20;
  localparam int IDX_W = 5;
  localparam logic [15:0] VEC_BASE = 16'h0010;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam logic [15:0] VEC_PORTC_PIN0 = 16'h0036;
  localparam logic [15:0] VEC_RESERVED_NEXT = 16'h0038;
  // ==========================================================================
  // Priority codes
  typedef enum logic [1:0] {
    PRIO_OFF = 2'h0,
    PRIO_LOW = 2'h1,
    PRIO_NOMINAL = 2'h2,
    PRIO_HIGH = 2'h3
  } prio_t;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic req;
    prio_t level;
    logic [15:0] vector;
  } delivery_t;
endpackage : pie_pkg
`default_nettype wire

// ===== hw/prioritized_interrupt_enable.sv
// Vectored interrupt controller with two-bit per-source priority enables.
`timescale 1ns/10ps
`default_nettype none
module prioritized_interrupt_enable (
  input wire logic clock_in, // System clock, 250 MHz
  input wire logic srst_in, // Synchronous reset, active high
  input wire pie_pkg::bus_req_t bus_in, // Register access request
  output logic [7:0] rd_data_out, // Read data, cycle after read
  input wire logic [7:0] group0_src_in, // Group 0 request pulses
  input wire logic [7:0] group1_src_in, // Group 1 request pulses
  input wire logic [3:0] portc_pins_in, // Port C pins, asynchronous
  input wire logic enable_int_instr_in, // Core executed enable-interrupt
  input wire logic return_from_int_instr_in, // Core executed return
  input wire logic disable_int_instr_in, // Core executed disable
  input wire logic core_ack_in, // Core takes offered interrupt
  output pie_pkg::delivery_t delivery_out, // Offered request to core
  output logic int_out // Event interrupt, level
);
  // ==========================================================================
  // State
  logic [7:0] g0_flags_q, g0_en_hi_q, g0_en_lo_q;
  logic [7:0] g1_flags_q, g1_en_hi_q, g1_en_lo_q;
  logic [7:0] pc_flags_q, pc_en_hi_q, pc_en_lo_q;
  logic master_q;
  logic [7:0] evt_status_q, evt_mask_q;
  logic [7:0] rd_data_q;
  logic [3:0] pc_sync1_q, pc_sync2_q, pc_prev_q;
  logic req_q;
  logic [1:0] level_q;
  logic [15:0] vector_q;
  logic [pie_pkg::IDX_W-1:0] index_q;
  logic [3:0] pc_edge;
  logic taken;
  logic [pie_pkg::SRC_COUNT-1:0] clear_all, pend_all, hi_all, lo_all;
  logic [pie_pkg::SRC_COUNT-1:0] l3_req, l2_req, l1_req;
  logic found3, found2, found1, found_any;
  logic [pie_pkg::IDX_W-1:0] idx3, idx2, idx1, sel_idx;
  logic [1:0] sel_level;
  logic [15:0] sel_vector;
  logic wr_g0, wr_g1, wr_pc, wr_ctl, wr_evt;
  // ==========================================================================
  // Address decode
  assign wr_g0 = bus_in.wr && bus_in.addr == pie_pkg::GROUP0_FLAGS_OFS;
  assign wr_g1 = bus_in.wr && bus_in.addr == pie_pkg::GROUP1_FLAGS_OFS;
  assign wr_pc = bus_in.wr && bus_in.addr == pie_pkg::PORTC_FLAGS_OFS;
  assign wr_ctl = bus_in.wr && bus_in.addr == pie_pkg::INT_CONTROL_OFS;
  assign wr_evt = bus_in.wr && bus_in.addr == pie_pkg::EVENT_STATUS_OFS;
  // ==========================================================================
  // Port C pin synchroniser and edge detection on both edges.
  // The first stage may go metastable, so only the second stage is read.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pc_sync1_q <= 4'h0;
      pc_sync2_q <= 4'h0;
      pc_prev_q <= 4'h0;
    end else begin
      pc_sync1_q <= portc_pins_in;
      pc_sync2_q <= pc_sync1_q;
      pc_prev_q <= pc_sync2_q;
    end
  end
  assign pc_edge = pc_sync2_q ^ pc_prev_q;
  // ==========================================================================
  // Flag clearing for the source the core takes.
  assign taken = core_ack_in && req_q;
  assign clear_all = taken ? (pie_pkg::SRC_COUNT'(1) << index_q) : '0;
  // Hardware sets win over software writes and the acknowledge clear.
  // Only the flag offered together with the request is cleared by a take.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      g0_flags_q <= pie_pkg::REG_RESET;
      g1_flags_q <= pie_pkg::REG_RESET;
      pc_flags_q <= pie_pkg::REG_RESET;
    end else begin
      g0_flags_q <= (((wr_g0 ? bus_in.wdata : g0_flags_q) & ~clear_all[19:12])
        | group0_src_in) & pie_pkg::GROUP0_MASK;
      g1_flags_q <= (((wr_g1 ? bus_in.wdata : g1_flags_q) & ~clear_all[11:4])
        | group1_src_in) & pie_pkg::GROUP1_MASK;
      pc_flags_q <= (((wr_pc ? bus_in.wdata : pc_flags_q)
        & ~{4'h0, clear_all[3:0]}) | {4'h0, pc_edge}) & pie_pkg::PORTC_MASK;
    end
  end
  // ==========================================================================
  // Priority enable registers.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      g0_en_hi_q <= pie_pkg::REG_RESET;
      g0_en_lo_q <= pie_pkg::REG_RESET;
      g1_en_hi_q <= pie_pkg::REG_RESET;
      g1_en_lo_q <= pie_pkg::REG_RESET;
      pc_en_hi_q <= pie_pkg::REG_RESET;
      pc_en_lo_q <= pie_pkg::REG_RESET;
    end else if (bus_in.wr) begin
      unique case (bus_in.addr)
        pie_pkg::GROUP0_EN_HIGH_OFS: g0_en_hi_q <= bus_in.wdata;
        pie_pkg::GROUP0_EN_LOW_OFS: begin
          g0_en_lo_q <= bus_in.wdata & pie_pkg::GROUP0_MASK;
        end
        pie_pkg::GROUP1_EN_HIGH_OFS: g1_en_hi_q <= bus_in.wdata;
        pie_pkg::GROUP1_EN_LOW_OFS: g1_en_lo_q <= bus_in.wdata;
        pie_pkg::PORTC_EN_HIGH_OFS: begin
          pc_en_hi_q <= bus_in.wdata & pie_pkg::PORTC_MASK;
        end
        pie_pkg::PORTC_EN_LOW_OFS: begin
          pc_en_lo_q <= bus_in.wdata & pie_pkg::PORTC_MASK;
        end
        default: ;
      endcase
    end
  end
  // ==========================================================================
  // Master enable: enable and return instructions set it, the disable instruction and taking an interrupt clear it.
  // An enable or return instruction in the cycle of a take leaves the enable set.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      master_q <= 1'b0;
    end else if (enable_int_instr_in || return_from_int_instr_in) begin
      master_q <= 1'b1;
    end else if (disable_int_instr_in || taken) begin
      master_q <= 1'b0;
    end else if (wr_ctl) begin
      master_q <= bus_in.wdata[pie_pkg::MASTER_ENABLE_BIT];
    end
  end
  // ==========================================================================
  // Priority selection. Bit 19 is group 0 bit 7, bit 0 is port C pin 0,
  // so a higher bit position means an earlier vector.
  assign pend_all = {g0_flags_q, g1_flags_q, pc_flags_q[3:0]};
  assign hi_all = {g0_en_hi_q & pie_pkg::GROUP0_MASK, g1_en_hi_q,
    pc_en_hi_q[3:0]};
  assign lo_all = {g0_en_lo_q, g1_en_lo_q, pc_en_lo_q[3:0]};
  assign l3_req = pend_all & hi_all & lo_all;
  assign l2_req = pend_all & hi_all & ~lo_all;
  assign l1_req = pend_all & ~hi_all & lo_all;
  find_highest #(.N(pie_pkg::SRC_COUNT), .W(pie_pkg::IDX_W)) u_level3 (
    .req_in(l3_req),
    .found_out(found3),
    .index_out(idx3)
  );
  find_highest #(.N(pie_pkg::SRC_COUNT), .W(pie_pkg::IDX_W)) u_level2 (
    .req_in(l2_req),
    .found_out(found2),
    .index_out(idx2)
  );
  find_highest #(.N(pie_pkg::SRC_COUNT), .W(pie_pkg::IDX_W)) u_level1 (
    .req_in(l1_req),
    .found_out(found1),
    .index_out(idx1)
  );
  always_comb begin
    sel_idx = idx1;
    sel_level = pie_pkg::PRIO_LOW;
    if (found3) begin
      sel_idx = idx3;
      sel_level = pie_pkg::PRIO_HIGH;
    end else if (found2) begin
      sel_idx = idx2;
      sel_level = pie_pkg::PRIO_NOMINAL;
    end
  end
  assign found_any = found3 || found2 || found1;
  assign sel_vector = pie_pkg::VEC_BASE + pie_pkg::VEC_STEP
    * (16'(pie_pkg::SRC_COUNT - 1) - 16'(sel_idx));
  // ==========================================================================
  // Offer to the core.
  // The offer drops in the cycle after a take, so no second take can land
  // on a source that is already being served.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      req_q <= 1'b0;
      level_q <= pie_pkg::PRIO_OFF;
      vector_q <= 16'h0000;
      index_q <= '0;
    end else begin
      req_q <= master_q && found_any && !taken;
      level_q <= found_any ? sel_level : pie_pkg::PRIO_OFF;
      vector_q <= found_any ? sel_vector : 16'h0000;
      index_q <= sel_idx;
    end
  end
  assign delivery_out.req = req_q;
  assign delivery_out.level = pie_pkg::prio_t'(level_q);
  assign delivery_out.vector = vector_q;
  // ==========================================================================
  // Event status, written one to clear, and mask.
  // A new event in the cycle of its clear keeps the bit set.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      evt_status_q <= pie_pkg::REG_RESET;
      evt_mask_q <= pie_pkg::REG_RESET;
    end else begin
      evt_status_q[pie_pkg::EVT_TAKEN_BIT] <= taken
        || (evt_status_q[pie_pkg::EVT_TAKEN_BIT]
        && !(wr_evt && bus_in.wdata[pie_pkg::EVT_TAKEN_BIT]));
      evt_status_q[pie_pkg::EVT_PORTC_EDGE_BIT] <= (|pc_edge)
        || (evt_status_q[pie_pkg::EVT_PORTC_EDGE_BIT]
        && !(wr_evt && bus_in.wdata[pie_pkg::EVT_PORTC_EDGE_BIT]));
      evt_status_q[7:2] <= 6'h00;
      if (bus_in.wr && bus_in.addr == pie_pkg::EVENT_MASK_OFS) begin
        evt_mask_q <= bus_in.wdata & pie_pkg::EVENT_MASK_BITS;
      end
    end
  end
  assign int_out = |(evt_status_q & evt_mask_q);
  // ==========================================================================
  // Read port: data stand only in the cycle after the strobe.
  // Reads have no side effect on any flag.
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rd_data_q <= 8'h00;
    end else if (!bus_in.rd) begin
      rd_data_q <= 8'h00;
    end else begin
      unique case (bus_in.addr)
        pie_pkg::GROUP0_FLAGS_OFS: rd_data_q <= g0_flags_q;
        pie_pkg::GROUP0_EN_HIGH_OFS: rd_data_q <= g0_en_hi_q;
        pie_pkg::GROUP0_EN_LOW_OFS: rd_data_q <= g0_en_lo_q;
        pie_pkg::GROUP1_FLAGS_OFS: rd_data_q <= g1_flags_q;
        pie_pkg::GROUP1_EN_HIGH_OFS: rd_data_q <= g1_en_hi_q;
        pie_pkg::GROUP1_EN_LOW_OFS: rd_data_q <= g1_en_lo_q;
        pie_pkg::PORTC_FLAGS_OFS: rd_data_q <= pc_flags_q;
        pie_pkg::PORTC_EN_HIGH_OFS: rd_data_q <= pc_en_hi_q;
        pie_pkg::PORTC_EN_LOW_OFS: rd_data_q <= pc_en_lo_q;
        pie_pkg::INT_CONTROL_OFS: rd_data_q <= {master_q, 7'h00};
        pie_pkg::EVENT_STATUS_OFS: rd_data_q <= evt_status_q;
        pie_pkg::EVENT_MASK_OFS: rd_data_q <= evt_mask_q;
        default: rd_data_q <= 8'h00;
      endcase
    end
  end
  assign rd_data_out = rd_data_q;
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // Level checks exclude a take, as a take drops the offer.

  master_gates_offer_a: assert property (
    !master_q |=> !req_q)
    else $error("Request offered while master enable was clear.");

  enable_instr_sets_a: assert property (
    enable_int_instr_in |=> master_q ##1 (master_q || $past(taken)
      || $past(disable_int_instr_in) || $past(wr_ctl)))
    else $error("Enable instruction did not set master enable.");

  return_instr_sets_a: assert property (
    return_from_int_instr_in |=> master_q)
    else $error("Return instruction did not set master enable.");

  portc_reserved_zero_a: assert property (
    pc_flags_q[7:4] == 4'h0)
    else $error("Port C reserved flag bits are not zero.");

  portc_edge_flags_a: assert property (
    (pc_sync2_q[0] != pc_prev_q[0]) |=> pc_flags_q[0])
    else $error("Port C pin 0 edge did not set its flag.");

  offer_level_code_a: assert property (
    (master_q && found3 && !taken) |=> req_q
      && level_q == pie_pkg::PRIO_HIGH)
    else $error("High priority request not offered at level 3.");

  disabled_source_quiet_a: assert property (
    (master_q && !taken && pend_all != '0 && (hi_all | lo_all) == '0)
      |=> !req_q)
    else $error("Disabled source was offered to the core.");

  low_reserved_read_a: assert property (
    (bus_in.rd && bus_in.addr == pie_pkg::GROUP0_EN_LOW_OFS)
      |=> rd_data_out[7] == 1'b0 && rd_data_out[2:1] == 2'h0)
    else $error("Reserved group 0 low enable bits read non-zero.");

  pin0_lowest_vector_a: assert property (
    (req_q && vector_q == pie_pkg::VEC_PORTC_PIN0)
      |-> $past(pend_all[0])
        && level_q == $past({hi_all[0], lo_all[0]}))
    else $error("Port C pin 0 vector offered without its request.");

  highest_first_a: assert property (
    (req_q && $past(found3)) |-> level_q == pie_pkg::PRIO_HIGH
      && vector_q == pie_pkg::VEC_BASE + pie_pkg::VEC_STEP
        * (16'(pie_pkg::SRC_COUNT - 1) - 16'($past(idx3))))
    else $error("Lower level or later vector served before level 3.");

  take_clears_a: assert property (
    (taken && !enable_int_instr_in && !return_from_int_instr_in)
      |=> !master_q ##1 !req_q)
    else $error("Taking a request did not drop the master enable.");

  level2_offer_a: assert property (
    (master_q && !found3 && found2 && !taken)
      |=> req_q && level_q == pie_pkg::PRIO_NOMINAL)
    else $error("Nominal request not offered at level 2.");

  level1_offer_a: assert property (
    (master_q && !found3 && !found2 && found1 && !taken)
      |=> req_q && level_q == pie_pkg::PRIO_LOW)
    else $error("Low request not offered at level 1.");

  offer_matches_source_a: assert property (
    req_q |-> $past(pend_all[sel_idx])
      && level_q == $past({hi_all[sel_idx], lo_all[sel_idx]}))
    else $error("Offered level differs from the source enable pair.");

  low_reserved_reg_a: assert property (
    g0_en_lo_q[7] == 1'b0 && g0_en_lo_q[2:1] == 2'h0)
    else $error("Reserved group 0 low enable bits hold a one.");

  reserved_flags_quiet_a: assert property (
    (g0_flags_q & ~pie_pkg::GROUP0_MASK) == 8'h00)
    else $error("Reserved group 0 flag bit is set.");

  portc_enable_width_a: assert property (
    pc_en_hi_q[7:4] == 4'h0 && pc_en_lo_q[7:4] == 4'h0)
    else $error("Port C enable bits above pin 3 are set.");

  portc_all_edges_a: assert property (
    (pc_edge != 4'h0)
      |=> (pc_flags_q[3:0] & $past(pc_edge)) == $past(pc_edge))
    else $error("Port C pin edge did not set its pending flag.");

  master_write_a: assert property (
    (wr_ctl && !enable_int_instr_in && !return_from_int_instr_in
      && !disable_int_instr_in && !taken)
      |=> master_q == $past(bus_in.wdata[pie_pkg::MASTER_ENABLE_BIT]))
    else $error("Control write did not set the master enable.");

  disable_instr_a: assert property (
    (disable_int_instr_in && !enable_int_instr_in
      && !return_from_int_instr_in) |=> !master_q)
    else $error("Disable instruction left the master enable set.");

  service_clears_flag_a: assert property (
    (taken && !bus_in.wr && group0_src_in == 8'h00
      && group1_src_in == 8'h00 && pc_edge == 4'h0)
      |=> (pend_all & $past(clear_all)) == '0)
    else $error("Served request still shows its pending flag.");

  offer_taken_c: cover property (req_q ##[1:20] taken);
  pin0_served_c: cover property (
    req_q && vector_q == pie_pkg::VEC_PORTC_PIN0 && core_ack_in);
  level_preempt_c: cover property (found2 && found3 && master_q);
  event_int_c: cover property ($rose(int_out));
  level1_served_c: cover property (req_q && level_q == pie_pkg::PRIO_LOW);
endmodule : prioritized_interrupt_enable
`default_nettype wire
